// File: logic/pasc_regs.svh
// constants for the parallel add/subtract and borrow datapath slice
`ifndef PASC_REGS_SVH
`define PASC_REGS_SVH

// shift-type field encodings for the second register operand
`define PASC_SHT_LEFT 2'h0
`define PASC_SHT_RIGHT 2'h1
`define PASC_SHT_ARITH 2'h2
`define PASC_SHT_ROTATE 2'h3

// register numbers that make a wide encoding unpredictable
`define PASC_REG_STACK 4'hD
`define PASC_REG_PC 4'hF

// lane greater-or-equal patterns
`define PASC_GE_PAIR_SET 2'h3
`define PASC_GE_PAIR_CLR 2'h0

// shift amount meaning "extend through carry" or "by 32"
`define PASC_AMT_ZERO 5'h00

`endif

// File: logic/pasc_pkg.sv
// types for the parallel add/subtract and borrow datapath slice
package pasc_pkg;

   // operation selected by the decoder
   typedef enum logic [2:0]
   {
      OP_REV_SUB,
      OP_HALF_ADD,
      OP_BYTE_ADD,
      OP_EXCH_ADDSUB,
      OP_BORROW_IMM,
      OP_BORROW_NARROW,
      OP_BORROW_WIDE
   } pasc_op_e;

   // decoded request fields
   typedef struct packed
   {
      pasc_op_e op;
      logic set_bit;
      logic in_cond_block;
      logic [3:0] dest_idx;
      logic [3:0] first_src_reg_field;
      logic [3:0] second_src_reg_field;
      logic [1:0] shift_type;
      logic [2:0] upper_shift_amount_field;
      logic [1:0] lower_shift_amount_field;
      logic [31:0] imm32;
   } pasc_req_s;

   // register write-back
   typedef struct packed
   {
      logic [3:0] dest;
      logic [31:0] data;
   } pasc_wb_s;

   // program status flags held by the slice
   typedef struct packed
   {
      logic [3:0] ge;
      logic n;
      logic z;
      logic c;
      logic v;
   } pasc_flags_s;

endpackage

// File: logic/pasc_alu.sv
// parallel add/subtract and subtract-with-borrow datapath slice
`timescale 1ns/100ps
`include "pasc_regs.svh"
// Functional notes
// - reverse subtract: not first plus shifted plus one
// - halfword add packs two independent lane sums
// - halfword add sets GE pairs from lane signs
// - byte add packs four independent lane sums
// - byte add sets one GE bit per lane
// - exchange: low minus high, high plus low
// - exchange GE pairs follow difference and sum
// - immediate borrow: first plus inverted constant plus carry
// - borrow flags: N bit31, Z zero, C, V
// - wide forms other than the packed ones set flags when S is one
// - narrow form: shared field, no shift, outside block
// - zero amount with rotate type means extend-through-carry
// - wide forms naming 13 or 15 are unpredictable
// - packed forms undefined without signal-processing extension
// - wide borrow forms undefined without main extension
// - register borrow: first plus inverted shifted plus carry
// - shift types: left, right, arithmetic, rotate
module pasc_alu
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // extension presence, quasi-static configuration
   input wire logic dsp_ext_present,
   input wire logic main_ext_present,
   // request from decoder and register file
   input wire logic issue_valid,
   input wire logic cond_passed,
   input wire pasc_pkg::pasc_req_s req,
   input wire logic [31:0] src_a_val,
   input wire logic [31:0] src_b_val,
   // write-back, flags and faults
   output var logic wb_valid_q,
   output var pasc_pkg::pasc_wb_s wb_q,
   output var pasc_pkg::pasc_flags_s flags_q,
   output var logic undef_fault_q,
   output var logic unpredictable_q
);

   // adder with carry in: returns {carry, overflow, sum}
   function automatic logic [33:0] add_with_carry(input logic [31:0] a, input logic [31:0] b, input logic cin);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      add_with_carry = {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
   endfunction

   // immediate shift of the second operand, zero amount decoded per type
   function automatic logic [31:0] shift_op(input logic [31:0] v, input logic [1:0] t, input logic [4:0] amt,
                                            input logic cin);
      shift_op = v;
      case (t)
         `PASC_SHT_LEFT:
            shift_op = v << amt;
         `PASC_SHT_RIGHT:
            shift_op = (amt == `PASC_AMT_ZERO) ? 32'h0 : v >> amt;
         `PASC_SHT_ARITH:
            shift_op = (amt == `PASC_AMT_ZERO) ? {32{v[31]}} : 32'($signed(v) >>> amt);
         `PASC_SHT_ROTATE:
         begin
            // zero amount selects extend-through-carry
            if (amt == `PASC_AMT_ZERO)
               shift_op = {cin, v[31:1]};
            else
               shift_op = (v >> amt) | (v << (6'h20 - {1'b0, amt}));
         end
         default:
            shift_op = v;
      endcase
   endfunction

   // signed halfword lane add or subtract at full precision
   function automatic logic [16:0] half_lane(input logic [15:0] a, input logic [15:0] b, input logic sub);
      half_lane = sub ? {a[15], a} - {b[15], b} : {a[15], a} + {b[15], b};
   endfunction

   // register number that makes a wide encoding unpredictable
   function automatic logic bad_reg(input logic [3:0] r);
      bad_reg = (r == `PASC_REG_STACK) || (r == `PASC_REG_PC);
   endfunction

   logic [4:0] amt; // shift amount from both fields
   logic [31:0] shifted; // second operand after shift
   logic [31:0] add_a; // adder operands
   logic [31:0] add_b;
   logic add_cin;
   logic [33:0] add_out; // {carry, overflow, sum}
   logic [16:0] h_lo; // halfword add lanes
   logic [16:0] h_hi;
   logic [16:0] x_diff; // exchanged lanes
   logic [16:0] x_sum;
   logic [8:0] b_sum [4]; // byte lanes
   logic packed_op; // signal-processing forms
   logic wide_op; // 32-bit encodings
   logic undef_d; // undefined instruction
   logic unpred_d; // unpredictable register use
   logic exec_d; // operation takes effect
   logic setf_d; // N Z C V update
   logic [31:0] res_d; // result word
   logic [3:0] ge_d; // next lane flags

   // operand steering and the shared adder
   always_comb
   begin
      amt = {req.upper_shift_amount_field, req.lower_shift_amount_field};
      shifted = shift_op(src_b_val, req.shift_type, amt, flags_q.c);
      add_a = src_a_val;
      add_b = ~shifted;
      add_cin = flags_q.c;
      case (req.op)
         pasc_pkg::OP_REV_SUB:
         begin
            add_a = ~src_a_val;
            add_b = shifted;
            add_cin = 1'b1;
         end
         pasc_pkg::OP_BORROW_IMM:
            add_b = ~req.imm32;
         pasc_pkg::OP_BORROW_NARROW:
            add_b = ~src_b_val;
         default:
            add_b = ~shifted;
      endcase
      add_out = add_with_carry(add_a, add_b, add_cin);
   end

   // packed lane arithmetic
   always_comb
   begin
      h_lo = half_lane(src_a_val[15:0], src_b_val[15:0], 1'b0);
      h_hi = half_lane(src_a_val[31:16], src_b_val[31:16], 1'b0);
      x_diff = half_lane(src_a_val[15:0], src_b_val[31:16], 1'b1);
      x_sum = half_lane(src_a_val[31:16], src_b_val[15:0], 1'b0);
      for (int i = 0; i < 4; i++)
         b_sum[i] = {src_a_val[8*i+7], src_a_val[8*i+:8]} + {src_b_val[8*i+7], src_b_val[8*i+:8]};
   end

   // fault decode and execute qualification
   always_comb
   begin
      packed_op = (req.op == pasc_pkg::OP_HALF_ADD) || (req.op == pasc_pkg::OP_BYTE_ADD) ||
                  (req.op == pasc_pkg::OP_EXCH_ADDSUB);
      wide_op = (req.op != pasc_pkg::OP_BORROW_NARROW);
      // missing extension makes the encoding undefined
      undef_d = packed_op ? !dsp_ext_present : (wide_op && !main_ext_present);
      // immediate form has no second register
      unpred_d = !undef_d && wide_op && (bad_reg(req.dest_idx) || bad_reg(req.first_src_reg_field) ||
                 ((req.op != pasc_pkg::OP_BORROW_IMM) && bad_reg(req.second_src_reg_field)));
      exec_d = issue_valid && cond_passed && !undef_d && !unpred_d;
      // narrow form sets flags only outside a conditional block
      if (req.op == pasc_pkg::OP_BORROW_NARROW)
         setf_d = exec_d && !req.in_cond_block;
      else
         setf_d = exec_d && !packed_op && req.set_bit;
   end

   // result and lane flag selection
   always_comb
   begin
      res_d = add_out[31:0];
      ge_d = flags_q.ge;
      case (req.op)
         pasc_pkg::OP_HALF_ADD:
         begin
            res_d = {h_hi[15:0], h_lo[15:0]};
            ge_d = {h_hi[16] ? `PASC_GE_PAIR_CLR : `PASC_GE_PAIR_SET,
                    h_lo[16] ? `PASC_GE_PAIR_CLR : `PASC_GE_PAIR_SET};
         end
         pasc_pkg::OP_BYTE_ADD:
         begin
            res_d = {b_sum[3][7:0], b_sum[2][7:0], b_sum[1][7:0], b_sum[0][7:0]};
            ge_d = {~b_sum[3][8], ~b_sum[2][8], ~b_sum[1][8], ~b_sum[0][8]};
         end
         pasc_pkg::OP_EXCH_ADDSUB:
         begin
            res_d = {x_sum[15:0], x_diff[15:0]};
            ge_d = {x_sum[16] ? `PASC_GE_PAIR_CLR : `PASC_GE_PAIR_SET,
                    x_diff[16] ? `PASC_GE_PAIR_CLR : `PASC_GE_PAIR_SET};
         end
         default:
            res_d = add_out[31:0];
      endcase
   end

   // register write-back, data and destination load every cycle, valid only when executed
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wb_valid_q <= 1'b0;
         wb_q <= '0;
      end
      else
      begin
         wb_valid_q <= exec_d;
         wb_q.data <= res_d;
         // narrow form writes back to its shared field
         wb_q.dest <= wide_op ? req.dest_idx : req.first_src_reg_field;
      end
   end

   // status flag register
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         flags_q <= '0;
      else if (exec_d && packed_op)
         flags_q.ge <= ge_d;
      else if (setf_d)
      begin
         flags_q.n <= add_out[31];
         flags_q.z <= (add_out[31:0] == 32'h0);
         flags_q.c <= add_out[33];
         flags_q.v <= add_out[32];
      end
   end

   // one-cycle fault pulses to the decoder
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         undef_fault_q <= 1'b0;
         unpredictable_q <= 1'b0;
      end
      else
      begin
         undef_fault_q <= issue_valid && undef_d;
         unpredictable_q <= issue_valid && unpred_d;
      end
   end

   // operand copies for the checks below
   logic [31:0] opa_p;
   logic [31:0] opb_p;
   logic [31:0] imm_p;
   logic c_p;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         opa_p <= 32'h0;
         opb_p <= 32'h0;
         imm_p <= 32'h0;
         c_p <= 1'b0;
      end
      else
      begin
         opa_p <= src_a_val;
         opb_p <= src_b_val;
         imm_p <= req.imm32;
         c_p <= flags_q.c;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // an accepted request of one kind
   sequence s_go(pasc_pkg::pasc_op_e o);
      issue_valid && cond_passed && !undef_d && !unpred_d && req.op == o;
   endsequence

   // an accepted request with a given shift
   sequence s_shift(pasc_pkg::pasc_op_e o, logic [1:0] t, logic [4:0] a);
      s_go(o) ##0 (req.shift_type == t && amt == a);
   endsequence

   chk_rev_sub_calc: assert property (s_shift(pasc_pkg::OP_REV_SUB, `PASC_SHT_LEFT, 5'h00) |=>
      wb_valid_q && wb_q.data == (~opa_p) + opb_p + 32'h1)
      else $error("reverse subtract result wrong");
   chk_half_pack: assert property (s_go(pasc_pkg::OP_HALF_ADD) |=>
      wb_q.data == {16'(opa_p[31:16] + opb_p[31:16]), 16'(opa_p[15:0] + opb_p[15:0])})
      else $error("halfword add packing wrong");
   chk_half_ge: assert property (s_go(pasc_pkg::OP_HALF_ADD) |=>
      flags_q.ge[1:0] == {2{($signed({opa_p[15], opa_p[15:0]}) + $signed({opb_p[15], opb_p[15:0]})) >= 0}})
      else $error("halfword add low GE wrong");
   chk_byte_pack: assert property (s_go(pasc_pkg::OP_BYTE_ADD) |=>
      wb_q.data[31:24] == 8'(opa_p[31:24] + opb_p[31:24]))
      else $error("byte add top lane wrong");
   chk_byte_ge: assert property (s_go(pasc_pkg::OP_BYTE_ADD) |=>
      flags_q.ge[0] == (($signed({opa_p[7], opa_p[7:0]}) + $signed({opb_p[7], opb_p[7:0]})) >= 0))
      else $error("byte add GE bit wrong");
   chk_exch_pack: assert property (s_go(pasc_pkg::OP_EXCH_ADDSUB) |=>
      wb_q.data == {16'(opa_p[31:16] + opb_p[15:0]), 16'(opa_p[15:0] - opb_p[31:16])})
      else $error("exchanged add/subtract wrong");
   chk_exch_ge: assert property (s_go(pasc_pkg::OP_EXCH_ADDSUB) |=>
      flags_q.ge[3:2] == {2{($signed({opa_p[31], opa_p[31:16]}) + $signed({opb_p[15], opb_p[15:0]})) >= 0}})
      else $error("exchanged sum GE wrong");
   chk_borrow_imm: assert property (s_go(pasc_pkg::OP_BORROW_IMM) |=>
      wb_valid_q && wb_q.data == opa_p + ~imm_p + {31'h0, c_p})
      else $error("immediate borrow result wrong");
   chk_borrow_nz: assert property (s_go(pasc_pkg::OP_BORROW_WIDE) ##0 req.set_bit |=>
      flags_q.n == wb_q.data[31] && flags_q.z == (wb_q.data == 32'h0))
      else $error("borrow N or Z wrong");
   chk_sbit_clear: assert property (s_go(pasc_pkg::OP_BORROW_IMM) ##0 !req.set_bit |=> $stable(flags_q))
      else $error("flags changed with S clear");
   chk_narrow_block: assert property (s_go(pasc_pkg::OP_BORROW_NARROW) ##0 req.in_cond_block |=>
      $stable(flags_q) && wb_q.data == opa_p + ~opb_p + {31'h0, c_p})
      else $error("narrow borrow in block wrong");
   chk_carry_extend: assert property (s_shift(pasc_pkg::OP_BORROW_WIDE, `PASC_SHT_ROTATE, 5'h00) |=>
      wb_q.data == opa_p + ~{c_p, opb_p[31:1]} + {31'h0, c_p})
      else $error("extend-through-carry wrong");
   chk_unpred_dest: assert property (issue_valid && !undef_d && req.op != pasc_pkg::OP_BORROW_NARROW &&
      req.dest_idx == `PASC_REG_PC |=> unpredictable_q && !wb_valid_q)
      else $error("unpredictable register not flagged");
   chk_dsp_undef: assert property (issue_valid && packed_op && !dsp_ext_present |=>
      undef_fault_q && !wb_valid_q && flags_q.ge == $past(flags_q.ge))
      else $error("packed form not undefined");
   chk_main_undef: assert property (issue_valid && req.op == pasc_pkg::OP_BORROW_WIDE &&
      !main_ext_present |=> undef_fault_q && !wb_valid_q)
      else $error("wide borrow not undefined");
   chk_borrow_reg: assert property (s_shift(pasc_pkg::OP_BORROW_WIDE, `PASC_SHT_LEFT, 5'h03) |=>
      wb_q.data == opa_p + ~(opb_p << 3) + {31'h0, c_p})
      else $error("register borrow wrong");
   chk_right_by32: assert property (s_shift(pasc_pkg::OP_BORROW_WIDE, `PASC_SHT_RIGHT, 5'h00) |=>
      wb_q.data == opa_p + 32'hFFFFFFFF + {31'h0, c_p})
      else $error("right shift by 32 wrong");
   chk_cond_false: assert property (issue_valid && !cond_passed |=> !wb_valid_q && $stable(flags_q))
      else $error("failed condition had effect");
   chk_packed_nzcv: assert property (s_go(pasc_pkg::OP_EXCH_ADDSUB) |=>
      $stable({flags_q.n, flags_q.z, flags_q.c, flags_q.v}))
      else $error("packed form changed NZCV");

endmodule

// File: bench/pasc_regfile_model.sv
// register file model that feeds source operands and takes write-backs
`timescale 1ns/100ps
module pasc_regfile_model
(
   // clock
   input wire logic core_clk,
   // request fields that select the operands
   input wire pasc_pkg::pasc_req_s req,
   // write-back from the slice
   input wire logic wb_valid_q,
   input wire pasc_pkg::pasc_wb_s wb_q,
   // operand values
   output logic [31:0] src_a_val,
   output logic [31:0] src_b_val
);
   // sixteen general registers
   logic [31:0] regs [16];

   // operands are read straight from the array, no latency
   assign src_a_val = regs[req.first_src_reg_field];
   assign src_b_val = regs[req.second_src_reg_field];

   // start from a known state
   initial
   begin
      foreach (regs[i])
         regs[i] = 32'h0;
   end

   // write-back lands one edge after the slice reports it
   always @(posedge core_clk)
   begin
      if (wb_valid_q)
         regs[wb_q.dest] <= wb_q.data;
   end

   // preload a register while the slice is idle
   task automatic load(input logic [3:0] idx, input logic [31:0] val);
      regs[idx] = val;
   endtask
endmodule

// File: bench/test_pasc_alu.sv
// self-checking bench for the parallel add/subtract and borrow slice
`timescale 1ns/100ps
module test_pasc_alu;
   // clock, reset and configuration
   logic core_clk;
   logic sys_rst;
   logic dsp_ext_present;
   logic main_ext_present;
   // request side
   logic issue_valid;
   logic cond_passed;
   pasc_pkg::pasc_req_s req;
   logic [31:0] src_a_val;
   logic [31:0] src_b_val;
   // answer side
   logic wb_valid_q;
   pasc_pkg::pasc_wb_s wb_q;
   pasc_pkg::pasc_flags_s flags_q;
   logic undef_fault_q;
   logic unpredictable_q;
   // bookkeeping
   int error_cnt;
   int total_checks;
   pasc_pkg::pasc_flags_s exp_f; // flags as the bench expects them

   pasc_alu dut (.core_clk(core_clk), .sys_rst(sys_rst), .dsp_ext_present(dsp_ext_present),
      .main_ext_present(main_ext_present), .issue_valid(issue_valid), .cond_passed(cond_passed),
      .req(req), .src_a_val(src_a_val), .src_b_val(src_b_val), .wb_valid_q(wb_valid_q), .wb_q(wb_q),
      .flags_q(flags_q), .undef_fault_q(undef_fault_q), .unpredictable_q(unpredictable_q));

   pasc_regfile_model mdl (.core_clk(core_clk), .req(req), .wb_valid_q(wb_valid_q), .wb_q(wb_q),
      .src_a_val(src_a_val), .src_b_val(src_b_val));

   // 125 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // exact four-state compare
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // reference shifter for the second operand
   function automatic logic [31:0] shf(input logic [31:0] v, input logic [1:0] t, input logic [4:0] a,
      input logic c);
      case (t)
         2'h0: shf = v << a;
         2'h1: shf = (a == 5'h00) ? 32'h0 : v >> a;
         2'h2: shf = (a == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> a);
         default: shf = (a == 5'h00) ? {c, v[31:1]} : (v >> a) | (v << (6'h20 - {1'b0, a}));
      endcase
   endfunction

   // issue one request, work out the answer, check it one cycle later
   task automatic run(input pasc_pkg::pasc_op_e op, input logic s, input logic cb, input logic [3:0] d,
      input logic [3:0] n, input logic [3:0] m, input logic [1:0] t, input logic [4:0] am,
      input logic [31:0] imm, input logic cp);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] oa;
      logic [31:0] ob;
      logic [32:0] x;
      logic [16:0] h1;
      logic [16:0] h2;
      logic [8:0] y;
      logic [3:0] ge;
      logic ci;
      logic pk;
      logic und;
      logic unp;
      logic wr;
      logic setf;
      @(posedge core_clk);
      issue_valid <= 1'b1;
      cond_passed <= cp;
      req <= '{op, s, cb, d, n, m, t, am[4:2], am[1:0], imm};
      #1;
      a = mdl.regs[n];
      b = mdl.regs[m];
      pk = op inside {pasc_pkg::OP_HALF_ADD, pasc_pkg::OP_BYTE_ADD, pasc_pkg::OP_EXCH_ADDSUB};
      und = pk ? !dsp_ext_present : (op != pasc_pkg::OP_BORROW_NARROW) && !main_ext_present;
      unp = !und && (op != pasc_pkg::OP_BORROW_NARROW) && ((d inside {4'hD, 4'hF}) ||
         (n inside {4'hD, 4'hF}) || ((op != pasc_pkg::OP_BORROW_IMM) && (m inside {4'hD, 4'hF})));
      wr = cp && !und && !unp;
      setf = s;
      oa = a;
      ob = ~shf(b, t, am, exp_f.c);
      ci = exp_f.c;
      ge = 4'h0;
      // operands of the shared adder per operation
      case (op)
         pasc_pkg::OP_REV_SUB:
         begin
            oa = ~a;
            ob = shf(b, t, am, exp_f.c);
            ci = 1'b1;
         end
         pasc_pkg::OP_BORROW_IMM: ob = ~imm;
         pasc_pkg::OP_BORROW_NARROW:
         begin
            ob = ~b;
            setf = !cb;
            d = n;
         end
         default: ci = exp_f.c;
      endcase
      x = {1'b0, oa} + {1'b0, ob} + 33'(ci);
      // lane arithmetic for the packed forms
      if (op == pasc_pkg::OP_BYTE_ADD)
      begin
         for (int i = 0; i < 4; i++)
         begin
            y = {a[8*i+7], a[8*i+:8]} + {b[8*i+7], b[8*i+:8]};
            x[8*i+:8] = y[7:0];
            ge[i] = ~y[8];
         end
      end
      else if (pk)
      begin
         h1 = (op == pasc_pkg::OP_HALF_ADD) ? {a[15], a[15:0]} + {b[15], b[15:0]}
            : {a[15], a[15:0]} - {b[31], b[31:16]};
         h2 = {a[31], a[31:16]} + ((op == pasc_pkg::OP_HALF_ADD) ? {b[31], b[31:16]} : {b[15], b[15:0]});
         x[31:0] = {h2[15:0], h1[15:0]};
         ge = {{2{~h2[16]}}, {2{~h1[16]}}};
      end
      // expected flag update
      if (wr && pk)
         exp_f.ge = ge;
      else if (wr && setf)
      begin
         exp_f.n = x[31];
         exp_f.z = (x[31:0] == 32'h0);
         exp_f.c = x[32];
         exp_f.v = (oa[31] == ob[31]) && (x[31] != oa[31]);
      end
      @(posedge core_clk);
      issue_valid <= 1'b0;
      #1;
      chk(40'({wb_valid_q, undef_fault_q, unpredictable_q, flags_q}), 40'({wr, und, unp, exp_f}));
      if (wr)
         chk(40'(wb_q), 40'({d, x[31:0]}));
   endtask

   // single place where the run ends
   task automatic print_verdict();
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      dsp_ext_present = 1'b1;
      main_ext_present = 1'b1;
      issue_valid = 1'b0;
      cond_passed = 1'b0;
      req = '0;
      error_cnt = 0;
      total_checks = 0;
      exp_f = '0;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(40'({wb_valid_q, undef_fault_q, unpredictable_q, flags_q}), 40'h0);
      mdl.load(4'h0, 32'h0000_0005);
      mdl.load(4'h1, 32'h0000_0003);
      mdl.load(4'h2, 32'h8000_0000);
      mdl.load(4'h3, 32'h7FFF_8001);
      mdl.load(4'h4, 32'h0001_8000);
      run(pasc_pkg::OP_BORROW_IMM, 1, 0, 4'h5, 4'h0, 4'h0, 2'h0, 5'h00, 32'h3, 1);
      run(pasc_pkg::OP_BORROW_IMM, 1, 0, 4'h6, 4'h0, 4'h0, 2'h0, 5'h00, 32'h5, 1);
      run(pasc_pkg::OP_BORROW_IMM, 0, 0, 4'h7, 4'h2, 4'h0, 2'h0, 5'h00, 32'h1, 1);
      run(pasc_pkg::OP_BORROW_IMM, 1, 0, 4'h7, 4'h2, 4'h0, 2'h0, 5'h00, 32'h1, 1);
      for (int t = 0; t < 4; t++)
         run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h8, 4'h3, 4'h4, 2'(t), 5'h04, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h8, 4'h2, 4'h3, 2'h3, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 0, 0, 4'h9, 4'h3, 4'h2, 2'h3, 5'h01, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h9, 4'h0, 4'h2, 2'h1, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_NARROW, 1, 1, 4'h0, 4'h1, 4'h0, 2'h2, 5'h07, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_NARROW, 0, 0, 4'h0, 4'h1, 4'h4, 2'h2, 5'h07, 32'h0, 1);
      run(pasc_pkg::OP_REV_SUB, 1, 0, 4'hA, 4'h0, 4'h1, 2'h0, 5'h02, 32'h0, 1);
      run(pasc_pkg::OP_REV_SUB, 0, 0, 4'hB, 4'h4, 4'h3, 2'h2, 5'h10, 32'h0, 1);
      run(pasc_pkg::OP_HALF_ADD, 1, 0, 4'hC, 4'h3, 4'h4, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BYTE_ADD, 1, 0, 4'hC, 4'h3, 4'h4, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_EXCH_ADDSUB, 1, 0, 4'hC, 4'h3, 4'h4, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_EXCH_ADDSUB, 1, 0, 4'hC, 4'h4, 4'h0, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BYTE_ADD, 1, 0, 4'hC, 4'h4, 4'h4, 2'h0, 5'h00, 32'h0, 0);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'hC, 4'h2, 4'h2, 2'h0, 5'h00, 32'h0, 0);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'hD, 4'h0, 4'h1, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_IMM, 1, 0, 4'h6, 4'hF, 4'h0, 2'h0, 5'h00, 32'h1, 1);
      run(pasc_pkg::OP_BORROW_IMM, 1, 0, 4'h6, 4'h0, 4'hD, 2'h0, 5'h00, 32'h1, 1);
      run(pasc_pkg::OP_HALF_ADD, 1, 0, 4'hC, 4'h3, 4'hF, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_REV_SUB, 1, 0, 4'hA, 4'h1, 4'h0, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h8, 4'h3, 4'h4, 2'h0, 5'h03, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h9, 4'h2, 4'h3, 2'h2, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'hF, 4'h0, 4'h1, 2'h0, 5'h00, 32'h0, 1);
      @(posedge core_clk);
      dsp_ext_present <= 1'b0;
      run(pasc_pkg::OP_HALF_ADD, 1, 0, 4'hC, 4'h3, 4'h4, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_EXCH_ADDSUB, 1, 0, 4'hD, 4'h3, 4'h4, 2'h0, 5'h00, 32'h0, 0);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h8, 4'h3, 4'h4, 2'h0, 5'h01, 32'h0, 1);
      @(posedge core_clk);
      dsp_ext_present <= 1'b1;
      main_ext_present <= 1'b0;
      run(pasc_pkg::OP_BORROW_IMM, 1, 0, 4'h6, 4'h0, 4'h0, 2'h0, 5'h00, 32'h1, 1);
      run(pasc_pkg::OP_BORROW_WIDE, 1, 0, 4'h6, 4'h0, 4'h1, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BORROW_NARROW, 0, 0, 4'h0, 4'h2, 4'h1, 2'h0, 5'h00, 32'h0, 1);
      run(pasc_pkg::OP_BYTE_ADD, 1, 0, 4'hC, 4'h3, 4'h3, 2'h0, 5'h00, 32'h0, 1);
      print_verdict();
   end
endmodule
